// *** common/sdrp_pkg.sv ***
// Function
// - Select high: ignore traffic, reset interface
// - Accept or return data only while selected
// - Read strobe falling shifts next bit out
// - Capture data line on every write rise, except after an unknown identifier
// - One shared data line, both directions
// - Display memory of 32 four-bit locations
// - Memory bits drive pattern outputs directly
// - Read, write and read-modify-write accesses
// - Address advances after each written nibble, and after each read nibble in read mode
// - Data mode versus command mode decoding
// - Three-bit identifier: 110, 101, 100
// - Address MSB first, nibbles LSB first
// - Successive commands omit the identifier
package sdrp_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int SDRP_LOCS = 32;
  localparam int SDRP_NIB_W = 4;
  localparam int SDRP_ADDR_W = 6;
  localparam int SDRP_CMD_W = 9;
  localparam int SDRP_RAM_W = SDRP_LOCS * SDRP_NIB_W;

  // ****************************************
  // Pin vector positions and idle levels
  // ****************************************
  localparam int SDRP_PIN_CS = 0;
  localparam int SDRP_PIN_WR = 1;
  localparam int SDRP_PIN_RD = 2;
  localparam int SDRP_PIN_DAT = 3;
  localparam logic [3:0] SDRP_PIN_IDLE = 4'hf;

  // ****************************************
  // Mode identifiers and bit counts
  // ****************************************
  localparam logic [2:0] SDRP_ID_READ = 3'h6;
  localparam logic [2:0] SDRP_ID_WRITE = 3'h5;
  localparam logic [2:0] SDRP_ID_CMD = 3'h4;
  localparam logic [3:0] SDRP_ID_LAST = 4'h2;
  localparam logic [3:0] SDRP_ADDR_LAST = 4'h5;
  localparam logic [3:0] SDRP_CMD_LAST = 4'h8;
  localparam logic [1:0] SDRP_NIB_LAST = 2'h3;

  typedef enum logic [2:0] {
    SDRP_ST_ID = 3'b000,
    SDRP_ST_ADDR = 3'b001,
    SDRP_ST_DATA = 3'b010,
    SDRP_ST_CMD = 3'b011,
    SDRP_ST_SKIP = 3'b100
  } sdrp_state_e;

endpackage

// *** hdl/sdrp_top.sv ***
`timescale 1ns/1ps
module sdrp_top
  import sdrp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe,
  output logic [SDRP_RAM_W-1:0] seg_pattern,
  output logic [SDRP_CMD_W-1:0] cmd_word,
  output logic cmd_valid
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] prev;
    sdrp_state_e st;
    logic rd_mode;
    logic [2:0] id;
    logic [3:0] cnt;
    logic [SDRP_ADDR_W-1:0] addr;
    logic [1:0] wcnt;
    logic [1:0] rcnt;
    logic [SDRP_CMD_W-1:0] sh;
    logic [SDRP_NIB_W-1:0] nib;
    logic [SDRP_RAM_W-1:0] ram;
    logic dout;
    logic oe;
    logic [SDRP_CMD_W-1:0] cmd;
    logic cmd_v;
  } sdrp_regs_s;

  sdrp_regs_s q;
  sdrp_regs_s d;

  logic sel;
  logic wr_rise;
  logic rd_fall;
  logic wr_low;
  logic bit_in;
  logic [6:0] base;

  // Edges compare the second stage with its delayed copy; first stage feeds nothing else
  assign sel = !q.s2[SDRP_PIN_CS];
  assign wr_rise = q.s2[SDRP_PIN_WR] && !q.prev[SDRP_PIN_WR];
  assign rd_fall = !q.s2[SDRP_PIN_RD] && q.prev[SDRP_PIN_RD];
  assign wr_low = !q.s2[SDRP_PIN_WR];
  assign bit_in = q.s2[SDRP_PIN_DAT];
  assign base = {q.addr[4:0], 2'h0};

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.s1 = {data_in, rd_n, wr_n, cs_n};
    d.s2 = q.s1;
    d.prev = q.s2;
    d.cmd_v = 1'b0;
    if (!sel)
    begin
      // Deselect resets the serial interface and drops traffic
      d.st = SDRP_ST_ID;
      d.cnt = 4'h0;
      d.id = 3'h0;
      d.wcnt = 2'h0;
      d.rcnt = 2'h0;
      d.oe = 1'b0;
    end
    else
    begin
      // Host drives the line while the write strobe is low
      if (wr_low || q.st != SDRP_ST_DATA)
      begin
        d.oe = 1'b0;
      end
      if (wr_rise)
      begin
        unique case (q.st)
          SDRP_ST_ID:
          begin
            d.id = {q.id[1:0], bit_in};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == SDRP_ID_LAST)
            begin
              d.cnt = 4'h0;
              // Mode decode; an unknown code is swallowed until deselect
              if ({q.id[1:0], bit_in} == SDRP_ID_READ)
              begin
                d.st = SDRP_ST_ADDR;
                d.rd_mode = 1'b1;
              end
              else if ({q.id[1:0], bit_in} == SDRP_ID_WRITE)
              begin
                d.st = SDRP_ST_ADDR;
                d.rd_mode = 1'b0;
              end
              else if ({q.id[1:0], bit_in} == SDRP_ID_CMD)
              begin
                d.st = SDRP_ST_CMD;
              end
              else
              begin
                d.st = SDRP_ST_SKIP;
              end
            end
          end
          SDRP_ST_ADDR:
          begin
            // Address arrives most significant bit first
            d.addr = {q.addr[SDRP_ADDR_W-2:0], bit_in};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == SDRP_ADDR_LAST)
            begin
              d.st = SDRP_ST_DATA;
              d.cnt = 4'h0;
              d.wcnt = 2'h0;
              d.rcnt = 2'h0;
            end
          end
          SDRP_ST_DATA:
          begin
            // Nibble bits arrive least significant first
            d.nib[q.wcnt] = bit_in;
            d.wcnt = q.wcnt + 2'h1;
            if (q.wcnt == SDRP_NIB_LAST)
            begin
              d.ram[base +: SDRP_NIB_W] = {bit_in, q.nib[2:0]};
              d.addr = q.addr + 6'h01;
              d.rcnt = 2'h0;
            end
          end
          SDRP_ST_CMD:
          begin
            // Nine bits per command, repeated without a new identifier
            d.sh = {q.sh[SDRP_CMD_W-2:0], bit_in};
            d.cnt = q.cnt + 4'h1;
            if (q.cnt == SDRP_CMD_LAST)
            begin
              d.cmd = {q.sh[SDRP_CMD_W-2:0], bit_in};
              d.cmd_v = 1'b1;
              d.cnt = 4'h0;
            end
          end
          SDRP_ST_SKIP:
          begin
            d.cnt = q.cnt;
          end
          default:
          begin
            d.st = SDRP_ST_SKIP;
          end
        endcase
      end
      // Read bit goes out on the falling read strobe and holds until the next
      if (rd_fall && q.st == SDRP_ST_DATA)
      begin
        d.dout = q.ram[base + {5'h00, q.rcnt}];
        d.oe = 1'b1;
        d.rcnt = q.rcnt + 2'h1;
        // Only pure reads advance here; read-modify-write advances on write
        if (q.rcnt == SDRP_NIB_LAST && q.rd_mode)
        begin
          d.addr = q.addr + 6'h01;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.s1 <= SDRP_PIN_IDLE;
      q.s2 <= SDRP_PIN_IDLE;
      q.prev <= SDRP_PIN_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // Pattern outputs are the memory flops themselves, no command needed
  assign seg_pattern = q.ram;
  assign data_out = q.dout;
  assign data_oe = q.oe;
  assign cmd_word = q.cmd;
  assign cmd_valid = q.cmd_v;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence wr_bit_s;
    sel && wr_rise;
  endsequence

  sequence nib_done_s;
    wr_bit_s ##0 (q.st == SDRP_ST_DATA && q.wcnt == SDRP_NIB_LAST);
  endsequence

  sequence rd_bit_s;
    sel && rd_fall && q.st == SDRP_ST_DATA;
  endsequence

  AST_DESEL_RESET: assert property (!sel |=> q.st == SDRP_ST_ID && !q.oe)
    else $error("Interface not reset while deselected");
  AST_DESEL_HOLD: assert property (!sel |=> $stable(q.ram) && !q.cmd_v)
    else $error("Traffic accepted while deselected");
  AST_RD_SHIFT: assert property (rd_bit_s |=> q.oe && q.dout == $past(q.ram[base + {5'h00, q.rcnt}]))
    else $error("Read bit not presented");
  AST_WR_CAPTURE: assert property (wr_bit_s ##0 q.st == SDRP_ST_ID |=> q.id[0] == $past(bit_in))
    else $error("Write bit not captured");
  AST_RELEASE: assert property ((sel && wr_low) || q.st != SDRP_ST_DATA |=> !q.oe)
    else $error("Data line driven outside read phase");
  AST_NIB_STORE: assert property (nib_done_s |=> seg_pattern[$past(base) +: 4] == {$past(bit_in), $past(q.nib[2:0])})
    else $error("Nibble not shown on pattern outputs");
  AST_ADDR_INC: assert property (nib_done_s |=> q.addr == $past(q.addr) + 6'h01)
    else $error("Address did not advance");
  AST_CMD_MODE: assert property (wr_bit_s ##0 (q.st == SDRP_ST_ID && q.cnt == SDRP_ID_LAST && {q.id[1:0], bit_in} == SDRP_ID_CMD) |=> q.st == SDRP_ST_CMD)
    else $error("Command identifier not decoded");
  AST_CMD_DONE: assert property (wr_bit_s ##0 (q.st == SDRP_ST_CMD && q.cnt == SDRP_CMD_LAST) |=> cmd_valid ##1 (!cmd_valid && q.st == SDRP_ST_CMD))
    else $error("Command not delivered or mode lost");

endmodule

// *** sim/sdrp_host.sv ***
`timescale 1ns/1ps
// ****
// Host side of the serial link
// ****
module sdrp_host (
  input wire logic clk,
  input wire logic dat,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic hd,
  output logic hoe
);
  // Idle pins: strobes high, line released
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    hd = 1'b0;
    hoe = 1'b0;
  end
  // Pins move just after a rising edge, never on it
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // High pulse clears the interface before every identifier
  task automatic sel();
    cs_n = 1'b1;
    hoe = 1'b0;
    cyc(120);
    cs_n = 1'b0;
    cyc(100);
  endtask
  // Drive only after the strobe falls, so a device still answering has let go
  // Low 12 and high 13 cycles make one 125 ns strobe period
  task automatic wbit(input logic b);
    wr_n = 1'b0;
    cyc(6);
    hoe = 1'b1;
    hd = b;
    cyc(6);
    wr_n = 1'b1;
    cyc(13);
  endtask
  // Identifier, address and commands go MSB first
  task automatic wbits(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) wbit(v[i]);
  endtask
  // Nibbles go LSB first
  task automatic wnib(input logic [3:0] v);
    for (int i = 0; i < 4; i++) wbit(v[i]);
  endtask
  // Line released while the device answers; bit taken as the strobe rises
  task automatic rnib(output logic [3:0] v);
    hoe = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      rd_n = 1'b0;
      cyc(12);
      v[i] = dat;
      rd_n = 1'b1;
      cyc(13);
    end
  endtask
endmodule

// *** sim/sdrp_top_tb_top.sv ***
`timescale 1ns/1ps
module sdrp_top_tb_top;
  import sdrp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire cs_n, wr_n, rd_n, hd, hoe, data_out, data_oe, cmd_valid;
  wire [SDRP_RAM_W-1:0] seg_pattern;
  wire [SDRP_CMD_W-1:0] cmd_word;
  // Pull-up wins when nobody drives the line
  wire dat = data_oe ? data_out : (hoe ? hd : 1'b1);
  logic [SDRP_RAM_W-1:0] mdl = '0;
  logic [8:0] c;
  logic [8:0] cmd_q[$];
  logic [3:0] d;
  logic [3:0] r;
  int err_count = 0;
  int cmp_count = 0;
  int seed = 49;
  int npulse = 0;
  int a;
  // ****
  // Clock, reset, design and host
  // ****
  always #2.5 clk = ~clk;
  sdrp_top i_dut (.clk(clk), .rstn(rstn), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .data_in(dat), .data_out(data_out), .data_oe(data_oe), .seg_pattern(seg_pattern),
    .cmd_word(cmd_word), .cmd_valid(cmd_valid));
  sdrp_host i_host (.clk(clk), .dat(dat), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .hd(hd), .hoe(hoe));
  // ****
  // Checking
  // ****
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Both parties driving at once would corrupt every bit
  always @(posedge clk) if (hoe === 1'b1 && data_oe !== 1'b0) chk(data_oe, 1'b0);
  // Every command pulse is matched against the queue of commands sent
  always @(posedge clk)
  begin
    if (cmd_valid === 1'b1)
    begin
      npulse++;
      if (cmd_q.size() == 0)
        chk(cmd_valid, 1'b0);
      else
        chk(cmd_word, cmd_q.pop_front());
    end
  end
  // Watchdog sized well above the expected run
  initial
  begin
    #400000;
    err_count++;
    report_and_stop();
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    i_host.cyc(16);
    rstn = 1'b1;
    i_host.cyc(4);
    chk(seg_pattern, mdl);
    // Write run starting near the top so the address wraps
    a = 30 | ($random(seed) & 32);
    i_host.sel();
    i_host.wbits(9'(SDRP_ID_WRITE), 3);
    i_host.wbits(9'(a), 6);
    for (int i = 0; i < 5; i++)
    begin
      d = 4'($random(seed));
      i_host.wnib(d);
      mdl[4 * ((a + i) % 32) +: 4] = d;
      chk(seg_pattern, mdl);
    end
    $display("write test done");
    // Read run from the same place; address advances per nibble
    i_host.sel();
    i_host.wbits(9'(SDRP_ID_READ), 3);
    i_host.wbits(9'(a), 6);
    for (int i = 0; i < 5; i++)
    begin
      i_host.rnib(r);
      chk(r, mdl[4 * ((a + i) % 32) +: 4]);
    end
    $display("read test done");
    // Read-modify-write over three locations
    i_host.sel();
    i_host.wbits(9'(SDRP_ID_WRITE), 3);
    i_host.wbits(9'(a + 2), 6);
    for (int i = 2; i < 5; i++)
    begin
      i_host.rnib(r);
      chk(r, mdl[4 * ((a + i) % 32) +: 4]);
      d = ~r;
      i_host.wnib(d);
      mdl[4 * ((a + i) % 32) +: 4] = d;
      chk(seg_pattern, mdl);
    end
    $display("rmw test done");
    // Partial nibble dropped when select goes high
    i_host.sel();
    i_host.wbits(9'(SDRP_ID_WRITE), 3);
    i_host.wbits(9'(a), 6);
    i_host.wbits(9'h1ff, 3);
    i_host.sel();
    chk(seg_pattern, mdl);
    $display("abort test done");
    // Unknown identifier: the rest of the select period must be ignored
    i_host.wbits(9'h007, 3);
    i_host.wbits(9'h1ff, 9);
    i_host.wnib(4'hf);
    chk(seg_pattern, mdl);
    chk(npulse, 0);
    i_host.sel();
    $display("unknown id test done");
    // Two commands, the second without its identifier
    i_host.wbits(9'(SDRP_ID_CMD), 3);
    for (int i = 0; i < 2; i++)
    begin
      c = 9'($random(seed));
      cmd_q.push_back(c);
      i_host.wbits(c, 9);
      chk(cmd_word, c);
    end
    chk(npulse, 2);
    chk(seg_pattern, mdl);
    $display("command test done");
    report_and_stop();
  end
endmodule
